// file: src/pin_mux_cell.v
// One pin's output and pull-up control.
// Assumes the general I/O settings and alternate function are given per pin.
`timescale 1ns/1ps

module pin_mux_cell (
    // Pin settings
    input  wire alt_sel,
    input  wire alt_drive,
    input  wire alt_data,
    input  wire dir_bit,
    input  wire data_bit,
    input  wire pull_bit,
    // Pad controls
    output wire pad_out,
    output wire pad_oe_n,
    output wire pad_pullup
);

    // ======================================================================
    // Output select
    // General I/O settings only when the pin is not taken by the alternate
    assign pad_out    = alt_sel ? alt_data : data_bit;
    assign pad_oe_n   = alt_sel ? ~alt_drive : ~dir_bit;
    // Pull-up only for a general I/O input pin
    assign pad_pullup = ~alt_sel & ~dir_bit & pull_bit;

endmodule // pin_mux_cell

// file: src/port3_gpio_pin_mux.v
// Eight-pin general-purpose port with pin function select for a serial unit.
// Assumes pins are synchronous to mclk; the serial unit lives elsewhere.
`include "port3_map.vh"
`timescale 1ns/1ps

module port3_gpio_pin_mux #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    // Register port
    input  wire [15:0]      reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    // Pins
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe_n,
    output wire [WIDTH-1:0] pin_pullup,
    // Serial unit side
    input  wire             serial_data_out,
    input  wire             serial_clock_out,
    input  wire             serial_clock_source_bit,
    output wire             serial_data_in,
    output wire             serial_clock_in
);

    // ======================================================================
    // Registers
    reg  [WIDTH-1:0] port_output_data_r;
    reg  [WIDTH-1:0] pin_direction_r;
    reg  [WIDTH-1:0] pullup_control_r;
    reg  [2:0]       pin_function_select_r;
    reg  [7:0]       rdata_nxt;
    wire [7:0]       func_read;
    wire [WIDTH-1:0] alt_sel;
    wire [WIDTH-1:0] alt_drive;
    wire [WIDTH-1:0] alt_data;
    wire [WIDTH-1:0] port_read;

    // Register writes
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port_output_data_r    <= `PORT_OUTPUT_DATA_RST;
            pin_direction_r       <= `PIN_DIRECTION_RST;
            pullup_control_r      <= `PULLUP_CONTROL_RST;
            pin_function_select_r <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `PORT_OUTPUT_DATA_ADDR:    port_output_data_r    <= reg_wdata[WIDTH-1:0];
                `PIN_DIRECTION_ADDR:       pin_direction_r       <= reg_wdata[WIDTH-1:0];
                `PULLUP_CONTROL_ADDR:      pullup_control_r      <= reg_wdata[WIDTH-1:0];
                `PIN_FUNCTION_SELECT_ADDR: pin_function_select_r <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Readback
    // Output bits read the latch, input bits the pin
    assign port_read = (pin_direction_r & port_output_data_r) | (~pin_direction_r & pin_in);
    assign func_read = `FUNC_RESERVED_MASK | {5'h00, pin_function_select_r};

    // Read data select
    always @* begin
        case (reg_addr)
            `PORT_OUTPUT_DATA_ADDR:    rdata_nxt = port_read;
            `PIN_DIRECTION_ADDR:       rdata_nxt = `DIRECTION_READ_VALUE;
            `PULLUP_CONTROL_ADDR:      rdata_nxt = pullup_control_r;
            `PIN_FUNCTION_SELECT_ADDR: rdata_nxt = func_read;
            default:                   rdata_nxt = `UNMAPPED_READ_VALUE;
        endcase
    end

    // Read data registered, valid only the cycle after the strobe
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    // ======================================================================
    // Alternate function per pin
    assign alt_sel   = {{(WIDTH-3){1'b0}}, pin_function_select_r};
    assign alt_drive = {{(WIDTH-3){1'b0}}, 1'b1, 1'b0, ~serial_clock_source_bit};
    assign alt_data  = {{(WIDTH-3){1'b0}}, serial_data_out, 1'b0, serial_clock_out};

    // Serial inputs routed from the pins, idle low when not selected
    assign serial_data_in  = pin_function_select_r[`SERIAL_IN_SELECT_BIT] & pin_in[1];
    assign serial_clock_in = pin_function_select_r[`SERIAL_CLOCK_SELECT_BIT]
                             & serial_clock_source_bit & pin_in[0];

    // ======================================================================
    // Pin cells
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            pin_mux_cell u_cell (
                .alt_sel    (alt_sel[i]),
                .alt_drive  (alt_drive[i]),
                .alt_data   (alt_data[i]),
                .dir_bit    (pin_direction_r[i]),
                .data_bit   (port_output_data_r[i]),
                .pull_bit   (pullup_control_r[i]),
                .pad_out    (pin_out[i]),
                .pad_oe_n   (pin_oe_n[i]),
                .pad_pullup (pin_pullup[i])
            );
        end
    endgenerate

endmodule // port3_gpio_pin_mux

// file: src/port3_map.vh
// Register offsets, field positions, reset values for the 8-bit port block.
// Assumes a byte-wide register port with 16-bit addresses.
//
// What this block does
// - Port data register: eight output latches, one per pin, reset to zero.
// - Reading data returns the latched bit where the direction bit is 1.
// - Reading data returns the sampled pin level where the direction bit is 0.
// - Direction bit 1 makes the pin an output, 0 an input; reset zero.
// - Direction register is write-only; reading its address returns all ones.
// - Direction and data apply only while the pin is in general I/O mode.
// - Input pin pull-up is on when its pull-up bit is 1 and the pin is in general I/O mode, else off.
// - Pull-up register is read/write, eight bits, reset to zero.
// - Mode bits 7 to 3 read as 1, ignore writes; reset value 0xF8.
// - Mode bit 1 selects pin 1 as serial data input.
// - Serial clock pin is output when clock source bit is 0, input when 1.
`ifndef PORT3_MAP_VH
`define PORT3_MAP_VH

// ==========================================================================
// Register offsets
`define PIN_FUNCTION_SELECT_ADDR 16'hFFCA
`define PORT_OUTPUT_DATA_ADDR    16'hFFD6
`define PULLUP_CONTROL_ADDR      16'hFFE1
`define PIN_DIRECTION_ADDR       16'hFFE6

// ==========================================================================
// Reset values and read patterns
`define PORT_OUTPUT_DATA_RST     8'h00
`define PIN_DIRECTION_RST        8'h00
`define PULLUP_CONTROL_RST       8'h00
`define PIN_FUNCTION_SELECT_RST  8'hF8
`define FUNC_RESERVED_MASK       8'hF8
`define DIRECTION_READ_VALUE     8'hFF
`define UNMAPPED_READ_VALUE      8'h00

// ==========================================================================
// Field positions in the function select register
`define SERIAL_OUT_SELECT_BIT    2
`define SERIAL_IN_SELECT_BIT     1
`define SERIAL_CLOCK_SELECT_BIT  0

`endif

// file: verif/pin_partner.sv
// Far side model: pads with external drivers and pull-ups.
// Assumes pad controls come straight from the port block.
`timescale 1ns/1ps
module pin_partner (
    input wire         mclk,
    input wire [7:0]   pin_out, pin_oe_n, pin_pullup, ext, ext_en,
    output logic [7:0] pin_in
);
    // ==========================================
    // Pad level resolution
    logic [7:0] tog = 8'h55;
    // Undriven pads without pull-up show a changing pattern
    always @(posedge mclk) tog <= ~tog;
    // Device driver first, then external driver, then pull-up
    always_comb for (int i = 0; i < 8; i++) pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext[i] : pin_pullup[i] | tog[i];
endmodule // pin_partner

// file: verif/port3_assertions.sv
// Checker for the port block: register reads and pin controls.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/1ps
module port3_assertions (
    // Clock, reset, register port
    input wire        mclk, sys_rst, reg_wr, reg_rd,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata, reg_rdata,
    // Pins and serial unit
    input wire [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup,
    input wire        serial_data_out, serial_clock_out, serial_clock_source_bit, serial_data_in, serial_clock_in
);
    // ==========================================
    // Register and pin relations
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_mode_wr; reg_wr && reg_addr == 16'hFFCA; endsequence
    sequence s_data_rd; reg_rd && reg_addr == 16'hFFD6; endsequence
    a_dir_reads_ones: assert property (reg_rd && reg_addr == 16'hFFE6 |=> reg_rdata == 8'hFF) else $error("dir read");
    a_mode_reads_high: assert property (reg_rd && reg_addr == 16'hFFCA |=> reg_rdata[7:3] == 5'h1F) else $error("mode read");
    a_dir_sets_oe: assert property (reg_wr && reg_addr == 16'hFFE6 |=> pin_oe_n[7] == !$past(reg_wdata[7])) else $error("dir oe");
    a_out_follows: assert property (reg_wr && reg_addr == 16'hFFD6 ##1 !pin_oe_n[7] |-> pin_out[7] == $past(reg_wdata[7])) else $error("out");
    a_pull_input_only: assert property ((pin_pullup & ~pin_oe_n) == 8'h00) else $error("pull-up on output");
    a_pin_read: assert property (s_data_rd ##0 pin_oe_n[7] |=> reg_rdata[7] == $past(pin_in[7])) else $error("pin read");
    a_latch_read: assert property (s_data_rd ##0 !pin_oe_n[7] |=> reg_rdata[7] == $past(pin_out[7])) else $error("latch read");
    a_serial_in: assert property (s_mode_wr |=> serial_data_in == ($past(reg_wdata[1]) & pin_in[1])) else $error("sin");
    a_clock_in: assert property (s_mode_wr |=> serial_clock_in == ($past(reg_wdata[0]) & serial_clock_source_bit & pin_in[0])) else $error("sck in");
    a_so_drive: assert property (s_mode_wr ##0 reg_wdata[2] |=> !pin_oe_n[2] && pin_out[2] == serial_data_out) else $error("so");
endmodule // port3_assertions

// file: verif/test_port3_gpio_pin_mux.sv
// Testbench for the port block: reset values, table of register cases, then pin functions and a mid-run reset.
// Assumes the pad model and checker files are compiled first.
`timescale 1ns/1ps
module test_port3_gpio_pin_mux;
    // ==========================================
    // Signals and tasks
    logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic serial_data_out = 1, serial_clock_out = 0, serial_clock_source_bit = 0, serial_data_in, serial_clock_in;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_in, pin_out, pin_oe_n, pin_pullup, rv;
    logic [7:0] ext = 8'h33, ext_en = 8'hFF;
    logic [23:0] rows [6] = '{24'hE6F0FF, 24'hE13C3C, 24'hD65A53, 24'hCA07FF, 24'hCA00F8, 24'hE0FF00};
    int err_total = 0, samples_checked = 0;
    port3_gpio_pin_mux i_port3_gpio_pin_mux (.*);
    pin_partner i_pin_partner (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
        .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
    initial forever #4 mclk = ~mclk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {8'hFF, a, d, 1'b1};
        @(posedge mclk) reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk) {reg_addr, reg_rd} <= {8'hFF, a, 1'b1};
        @(posedge mclk) reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic wrap_up;
        $display("checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
    // Reset values, table rows, then alternate functions
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        chk(pin_oe_n, 8'hFF);
        chk(pin_pullup, 8'h00);
        rd(8'hCA); chk(rv, 8'hF8);
        rd(8'hE1); chk(rv, 8'h00);
        wr(8'hE6, 8'hFF); rd(8'hD6); chk(rv, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]); chk(rv, rows[i][7:0]);
        end
        chk(pin_pullup, 8'h0C);
        $display("table test done");
        wr(8'hCA, 8'h07);
        chk(pin_oe_n, 8'h0A);
        chk(pin_out & 8'h05, 8'h04);
        chk(pin_pullup, 8'h08);
        chk({7'h00, serial_data_in}, 8'h01);
        @(posedge mclk) serial_clock_source_bit <= 1'b1;
        #1 chk(pin_oe_n, 8'h0B);
        chk({7'h00, serial_clock_in}, 8'h01);
        @(posedge mclk) serial_clock_source_bit <= 1'b0;
        serial_clock_out <= 1'b1;
        #1 chk(pin_out & 8'h05, 8'h05);
        $display("alternate test done");
        // Reset in mid-run brings direction, pull-up and mode registers back
        @(posedge mclk) sys_rst <= 1'b1;
        @(posedge mclk) sys_rst <= 1'b0;
        #1 chk(pin_oe_n, 8'hFF);
        chk(pin_pullup, 8'h00);
        rd(8'hCA); chk(rv, 8'hF8);
        rd(8'hE1); chk(rv, 8'h00);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule // test_port3_gpio_pin_mux
bind port3_gpio_pin_mux port3_assertions i_port3_assertions (.*);
